// ---- verilog/iosad_pkg.sv ----
// Shared constants and types for the I/O space address decoder
package iosad_pkg;

    // ------------------------------------------------------------
    // Core operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_IO_READ,               // Dedicated I/O read
        OP_IO_WRITE,              // Dedicated I/O write
        OP_IO_BIT_SET_INSTR,      // Single-bit set on I/O register
        OP_IO_BIT_CLEAR_INSTR,    // Single-bit clear on I/O register
        OP_SKIP_IF_IO_BIT_HIGH,   // Test bit, skip when one
        OP_SKIP_IF_IO_BIT_LOW,    // Test bit, skip when zero
        OP_DATA_LOAD_INSTRS,      // Load from data space
        OP_DATA_STORE_INSTRS      // Store to data space
    } iosad_op_t;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [15:0] IO_BIT_LAST = 16'h001f;     // Top of bit-accessible range
    localparam logic [15:0] IO_WIN_LAST = 16'h003f;     // Top of dedicated I/O window
    localparam logic [15:0] DATA_IO_OFFSET = 16'h0020;  // I/O address to data address
    localparam logic [15:0] EXT_FIRST = 16'h0060;       // First extended I/O data address
    localparam logic [15:0] EXT_LAST = 16'h00ff;        // Last extended I/O data address
    localparam int IO_DEPTH = 224;                      // I/O plus extended locations

    // ------------------------------------------------------------
    // Write-one-to-clear flag layout
    // ------------------------------------------------------------
    localparam logic [7:0] W1C_REG_IDX = 8'h18;         // Register holding clearable flags
    localparam logic [7:0] W1C_REG_MASK = 8'h0f;        // Its clearable flag bits

    // Flag bits of a location that clear on a written one
    function automatic logic [7:0] w1c_mask(input logic [7:0] idx);
        w1c_mask = (idx == W1C_REG_IDX) ? W1C_REG_MASK : 8'h00;
    endfunction : w1c_mask

endpackage : iosad_pkg

// ---- verilog/iosad_store.sv ----
// I/O register store with write-one-to-clear flags
`timescale 1ns/1ps
module iosad_store
    import iosad_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Read port, data one cycle later
    input wire logic rd_en_i,
    input wire logic [7:0] rd_idx_i,
    output logic [7:0] rd_data_o,
    // Write port
    input wire logic wr_en_i,
    input wire logic [7:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    // Hardware flag setting from peripherals
    input wire logic set_en_i,
    input wire logic [7:0] set_idx_i,
    input wire logic [7:0] set_bits_i
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem_q [IO_DEPTH];  // Register contents
    logic [7:0] rd_data_d;         // Next read data
    logic [7:0] wr_val;            // Merged value for a write
    logic same_idx;                // Set and write hit one location

    // ------------------------------------------------------------
    // Write merge
    // ------------------------------------------------------------
    // Flag bits clear on one and hold on zero; others take the data.
    // A flag set by hardware in the same cycle wins over the clear.
    always_comb
    begin
        same_idx = set_en_i && (set_idx_i == wr_idx_i);
        wr_val = (wr_data_i & ~w1c_mask(wr_idx_i))
               | (mem_q[wr_idx_i] & w1c_mask(wr_idx_i) & ~wr_data_i);
        if (same_idx)
        begin
            wr_val = wr_val | set_bits_i;
        end
        rd_data_d = rd_en_i ? mem_q[rd_idx_i] : rd_data_o;
    end

    // Array has no reset; contents are software defined
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_idx_i] <= wr_val;
        end
        if (set_en_i && !(wr_en_i && same_idx))
        begin
            mem_q[set_idx_i] <= mem_q[set_idx_i] | set_bits_i;
        end
    end

    // Read data register
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rd_data_o <= 8'h00;
        end
        else
        begin
            rd_data_o <= rd_data_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_w1c_flag_clear: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_en_i && !set_en_i && wr_idx_i == W1C_REG_IDX)
        |=> ((mem_q[W1C_REG_IDX] & W1C_REG_MASK)
             == ($past(mem_q[W1C_REG_IDX]) & W1C_REG_MASK & ~$past(wr_data_i))))
        else $error("flag bits not cleared by written ones");

endmodule : iosad_store

// ---- verilog/iosad_decoder.sv ----
// I/O space address decoder: window, offset, extended range, bit access
// Behaviour
// - bit set/clear only on addresses 00-1F
// - skip instructions test bits in 00-1F
// - I/O read/write address window 00-3F
// - data address equals I/O address plus 20
// - loads and stores reach every I/O location
// - extended 60-FF reachable by load/store only
// - compatibility mode maps extended range to SRAM
// - flagged bits clear on written one
// - bit set/clear rewrite whole register
`timescale 1ns/1ps
module iosad_decoder
    import iosad_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Core request
    input wire logic req_valid_i,
    input wire iosad_op_t req_op_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [2:0] req_bit_i,
    input wire logic [7:0] req_wdata_i,
    output logic req_ready_o,
    // Core answer
    output logic done_o,
    output logic err_o,
    output logic skip_o,
    output logic [7:0] rdata_o,
    // Mode strap
    input wire logic compat_mode_i,
    // Peripheral flag setting
    input wire logic flag_set_i,
    input wire logic [7:0] flag_set_idx_i,
    input wire logic [7:0] flag_set_bits_i,
    // SRAM port for the extended range in compatibility mode
    output logic sram_req_o,
    output logic sram_we_o,
    output logic [15:0] sram_addr_o,
    output logic [7:0] sram_wdata_o,
    input wire logic [7:0] sram_rdata_i
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,   // Waiting for a request
        ST_WAIT,   // Read issued, data next cycle
        ST_USE     // Read data at hand
    } iosad_state_t;
    iosad_state_t state_q, state_d;    // Sequencer
    iosad_op_t op_q, op_d;             // Operation in flight
    logic [7:0] idx_q, idx_d;          // Store index in flight
    logic [2:0] bit_q, bit_d;          // Bit number in flight
    logic to_sram_q, to_sram_d;        // Target is SRAM
    logic ready_d, done_d, err_d, skip_d;
    logic [7:0] rdata_d;
    logic sram_req_d, sram_we_d;
    logic [15:0] sram_addr_d;
    logic [7:0] sram_wdata_d;
    logic mem_rd, mem_wr;              // Store strobes
    logic [7:0] mem_rd_idx, mem_wr_idx, mem_wdata, mem_rdata;
    logic [7:0] rd_val;                // Read value in ST_USE
    logic legal, is_io_op, is_bit_op, is_write, to_ext;
    logic [7:0] new_idx;

    // Data-space address to store index
    function automatic logic [7:0] data_to_idx(input logic [15:0] addr);
        logic [15:0] diff;
        diff = addr - DATA_IO_OFFSET;
        data_to_idx = diff[7:0];
    endfunction : data_to_idx

    // Operations that use the dedicated I/O address field
    function automatic logic io_field_op(input iosad_op_t op);
        io_field_op = (op != OP_DATA_LOAD_INSTRS) && (op != OP_DATA_STORE_INSTRS);
    endfunction : io_field_op

    // ------------------------------------------------------------
    // Register store
    // ------------------------------------------------------------
    iosad_store u_store (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .rd_en_i(mem_rd),
        .rd_idx_i(mem_rd_idx),
        .rd_data_o(mem_rdata),
        .wr_en_i(mem_wr),
        .wr_idx_i(mem_wr_idx),
        .wr_data_i(mem_wdata),
        .set_en_i(flag_set_i),
        .set_idx_i(flag_set_idx_i),
        .set_bits_i(flag_set_bits_i)
    );

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Dedicated I/O ops carry the I/O address; loads and stores the data address
    always_comb
    begin
        is_io_op = io_field_op(req_op_i);
        is_bit_op = is_io_op && (req_op_i != OP_IO_READ) && (req_op_i != OP_IO_WRITE);
        is_write = (req_op_i == OP_IO_WRITE) || (req_op_i == OP_DATA_STORE_INSTRS);
        if (is_io_op)
        begin
            legal = (req_addr_i <= IO_WIN_LAST)
                  && (!is_bit_op || (req_addr_i <= IO_BIT_LAST));
            new_idx = req_addr_i[7:0];
            to_ext = 1'b0;
        end
        else
        begin
            legal = (req_addr_i >= DATA_IO_OFFSET) && (req_addr_i <= EXT_LAST);
            new_idx = data_to_idx(req_addr_i);
            to_ext = compat_mode_i && (req_addr_i >= EXT_FIRST);
        end
    end

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    // Reads take three cycles so that the store and SRAM answer alike;
    // bit set/clear write the whole byte back in the final cycle.
    always_comb
    begin
        state_d = state_q;
        op_d = op_q;
        idx_d = idx_q;
        bit_d = bit_q;
        to_sram_d = to_sram_q;
        done_d = 1'b0;
        err_d = 1'b0;
        skip_d = 1'b0;
        rdata_d = rdata_o;
        sram_req_d = 1'b0;
        sram_we_d = 1'b0;
        sram_addr_d = sram_addr_o;
        sram_wdata_d = sram_wdata_o;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_rd_idx = new_idx;
        mem_wr_idx = new_idx;
        mem_wdata = req_wdata_i;
        rd_val = to_sram_q ? sram_rdata_i : mem_rdata;
        case (state_q)
            ST_IDLE:
            begin
                if (req_valid_i)
                begin
                    op_d = req_op_i;
                    idx_d = new_idx;
                    bit_d = req_bit_i;
                    to_sram_d = to_ext;
                    if (!legal)
                    begin
                        // Out-of-range request is answered with an error
                        done_d = 1'b1;
                        err_d = 1'b1;
                    end
                    else if (to_ext)
                    begin
                        // Extended range acts as plain SRAM
                        sram_req_d = 1'b1;
                        sram_we_d = is_write;
                        sram_addr_d = req_addr_i;
                        sram_wdata_d = req_wdata_i;
                        done_d = is_write;
                        state_d = is_write ? ST_IDLE : ST_WAIT;
                    end
                    else if (is_write)
                    begin
                        mem_wr = 1'b1;
                        done_d = 1'b1;
                    end
                    else
                    begin
                        mem_rd = 1'b1;
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT: state_d = ST_USE;  // Store or SRAM read data is at hand next cycle
            ST_USE:
            begin
                state_d = ST_IDLE;
                done_d = 1'b1;
                mem_wr_idx = idx_q;
                case (op_q)
                    OP_IO_BIT_SET_INSTR:
                    begin
                        mem_wr = 1'b1;
                        mem_wdata = rd_val | (8'h01 << bit_q);
                    end
                    OP_IO_BIT_CLEAR_INSTR:
                    begin
                        mem_wr = 1'b1;
                        mem_wdata = rd_val & ~(8'h01 << bit_q);
                    end
                    OP_SKIP_IF_IO_BIT_HIGH: skip_d = rd_val[bit_q];
                    OP_SKIP_IF_IO_BIT_LOW: skip_d = !rd_val[bit_q];
                    default: rdata_d = rd_val;  // Reads and loads hand the byte over
                endcase
            end
            default: state_d = ST_IDLE;  // Unused encoding falls back to idle
        endcase
        ready_d = (state_d == ST_IDLE);
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= ST_IDLE;
            op_q <= OP_IO_READ;
            idx_q <= 8'h00;
            bit_q <= 3'h0;
            to_sram_q <= 1'b0;
            req_ready_o <= 1'b1;
            done_o <= 1'b0;
            err_o <= 1'b0;
            skip_o <= 1'b0;
            rdata_o <= 8'h00;
            sram_req_o <= 1'b0;
            sram_we_o <= 1'b0;
            sram_addr_o <= 16'h0000;
            sram_wdata_o <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            op_q <= op_d;
            idx_q <= idx_d;
            bit_q <= bit_d;
            to_sram_q <= to_sram_d;
            req_ready_o <= ready_d;
            done_o <= done_d;
            err_o <= err_d;
            skip_o <= skip_d;
            rdata_o <= rdata_d;
            sram_req_o <= sram_req_d;
            sram_we_o <= sram_we_d;
            sram_addr_o <= sram_addr_d;
            sram_wdata_o <= sram_wdata_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bit_op_range: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (req_valid_i && req_ready_o && is_bit_op && req_addr_i > IO_BIT_LAST)
        |=> (done_o && err_o))
        else $error("bit operation above bit range not refused");
    a_skip_high_test: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_q == ST_USE && op_q == OP_SKIP_IF_IO_BIT_HIGH)
        |=> (done_o && skip_o == $past(rd_val[bit_q])))
        else $error("skip result does not match tested bit");
    a_io_window_limit: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (req_valid_i && req_ready_o && (req_op_i == OP_IO_READ || req_op_i == OP_IO_WRITE))
        |=> (err_o == ($past(req_addr_i) > IO_WIN_LAST)))
        else $error("I/O window limit wrong");
    a_store_offset: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (req_valid_i && req_ready_o && req_op_i == OP_DATA_STORE_INSTRS && legal && !to_ext)
        |-> (mem_wr && mem_wr_idx == req_addr_i[7:0] - DATA_IO_OFFSET[7:0]))
        else $error("data address offset wrong");
    a_load_answer: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (req_valid_i && req_ready_o && req_op_i == OP_DATA_LOAD_INSTRS && legal)
        |=> !req_ready_o ##2 (done_o && !err_o && req_ready_o))
        else $error("load not answered in three cycles");
    a_ext_io_refused: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (req_valid_i && req_ready_o && is_io_op && req_addr_i >= EXT_FIRST)
        |-> (!mem_wr && !mem_rd) ##1 err_o)
        else $error("extended range reached by I/O instruction");
    a_compat_sram: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (req_valid_i && req_ready_o && !is_io_op && compat_mode_i
         && req_addr_i >= EXT_FIRST && req_addr_i <= EXT_LAST)
        |=> (sram_req_o && sram_addr_o == $past(req_addr_i) && !$past(mem_wr)))
        else $error("compatibility access did not reach SRAM");
    a_bit_clear_rmw: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_q == ST_USE && op_q == OP_IO_BIT_CLEAR_INSTR)
        |-> (mem_wr && mem_wdata == (rd_val & ~(8'h01 << bit_q))))
        else $error("bit clear did not rewrite whole register");

endmodule : iosad_decoder

// ---- tb/iosad_sram_model.sv ----
// Behavioural SRAM standing behind the decoder in compatibility mode
`timescale 1ns/1ps
module iosad_sram_model
(
    // Clock
    input wire logic clk_i,
    // Access from the decoder
    input wire logic sram_req_i,
    input wire logic sram_we_i,
    input wire logic [15:0] sram_addr_i,
    input wire logic [7:0] sram_wdata_i,
    output logic [7:0] sram_rdata_o
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem [256]; // Low address byte selects the cell
    // Write on request; read data stands the cycle after a read request
    always @(posedge clk_i)
    begin
        if (sram_req_i && sram_we_i)
            mem[sram_addr_i[7:0]] <= sram_wdata_i;
        if (sram_req_i && !sram_we_i)
            sram_rdata_o <= mem[sram_addr_i[7:0]];
        else
            sram_rdata_o <= ~sram_rdata_o; // Churn, so stale data never matches
    end
endmodule : iosad_sram_model

// ---- tb/io_space_address_decoder_test.sv ----
// Self-checking bench for the I/O space address decoder
`timescale 1ns/1ps
module io_space_address_decoder_test;
    import iosad_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 0;
    logic rst_b_i = 0;
    logic req_valid_i = 0;
    iosad_op_t req_op_i = OP_IO_READ;
    logic [15:0] req_addr_i = 16'h0000;
    logic [2:0] req_bit_i = 3'h0;
    logic [7:0] req_wdata_i = 8'h00;
    logic compat_mode_i = 0;
    logic flag_set_i = 0;
    logic [7:0] flag_set_idx_i = 8'h00;
    logic [7:0] flag_set_bits_i = 8'h00;
    logic req_ready_o, done_o, err_o, skip_o, sram_req_o, sram_we_o;
    logic [7:0] rdata_o, sram_wdata_o, sram_rdata_i, d, e;
    logic [15:0] sram_addr_o;
    logic [2:0] b; // Bit under test
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    // Expected answer noted by the driver
    typedef struct {logic err; logic skip; logic [7:0] rd; logic chk;} iosad_exp_t;
    iosad_exp_t exp_q[$];
    iosad_exp_t got_e;
    iosad_op_t r_op [8] = '{OP_IO_READ, OP_IO_WRITE, OP_IO_BIT_SET_INSTR,
        OP_IO_BIT_CLEAR_INSTR, OP_SKIP_IF_IO_BIT_HIGH, OP_SKIP_IF_IO_BIT_LOW,
        OP_DATA_LOAD_INSTRS, OP_DATA_STORE_INSTRS};
    logic [15:0] r_adr [8] = '{16'h0040, 16'h0040, 16'h0020, 16'h0020, 16'h0020,
        16'h0020, 16'h001f, 16'h0100};
    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    iosad_decoder i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
        .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_bit_i(req_bit_i),
        .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .done_o(done_o),
        .err_o(err_o), .skip_o(skip_o), .rdata_o(rdata_o), .compat_mode_i(compat_mode_i),
        .flag_set_i(flag_set_i), .flag_set_idx_i(flag_set_idx_i),
        .flag_set_bits_i(flag_set_bits_i), .sram_req_o(sram_req_o), .sram_we_o(sram_we_o),
        .sram_addr_o(sram_addr_o), .sram_wdata_o(sram_wdata_o), .sram_rdata_i(sram_rdata_i));
    iosad_sram_model i_sram (.clk_i(clk_i), .sram_req_i(sram_req_o), .sram_we_i(sram_we_o),
        .sram_addr_i(sram_addr_o), .sram_wdata_i(sram_wdata_o), .sram_rdata_o(sram_rdata_i));
    // 20 MHz clock
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic check_bit(input logic got, input logic want, input string what);
        comparisons++;
        if (got !== want)
        begin
            failures++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check_bit
    task automatic check_byte(input logic [7:0] got, input logic [7:0] want, input string what);
        comparisons++;
        if (got !== want)
        begin
            failures++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, want);
        end
    endtask : check_byte
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Driver: request held until taken on an edge with ready high
    // ------------------------------------------------------------
    task automatic req(input iosad_op_t op, input logic [15:0] a, input logic [2:0] b,
        input logic [7:0] wd, input logic er, input logic sk, input logic [7:0] rd,
        input logic chk);
        int n;
        n = 0;
        @(negedge clk_i);
        exp_q.push_back('{er, sk, rd, chk});
        req_valid_i = 1;
        req_op_i = op;
        req_addr_i = a;
        req_bit_i = b;
        req_wdata_i = wd;
        while (req_ready_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        req_valid_i = 0; // A lowered edge always separates two requests
    endtask : req
    task automatic rd_io(input logic [15:0] a, input logic [7:0] want);
        req(OP_IO_READ, a, 3'h0, 8'h00, 1'b0, 1'b0, want, 1'b1);
    endtask : rd_io
    task automatic wr(input iosad_op_t op, input logic [15:0] a, input logic [7:0] wd);
        req(op, a, 3'h0, wd, 1'b0, 1'b0, 8'h00, 1'b0);
    endtask : wr
    // ------------------------------------------------------------
    // Monitor: answers taken in order, SRAM used in compatibility only
    // ------------------------------------------------------------
    always @(negedge clk_i)
    begin
        if (done_o === 1'b1)
        begin
            if (exp_q.size() == 0)
                check_bit(1'b1, 1'b0, "answer with nothing pending");
            else
            begin
                got_e = exp_q.pop_front();
                check_bit(err_o, got_e.err, "error flag");
                check_bit(skip_o, got_e.skip, "skip flag");
                if (got_e.chk)
                    check_byte(rdata_o, got_e.rd, "read data");
            end
        end
        if (sram_req_o === 1'b1)
        begin
            check_bit(compat_mode_i, 1'b1, "sram hit outside compat");
            check_byte(sram_addr_o[7:0], 8'h90, "sram address");
            if (sram_we_o === 1'b1)
                check_byte(sram_wdata_o, d, "sram write data");
        end
    end
    // Hang guard: the tests need well under a thousand cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            $display("wrong value at %0t: run timed out", $time);
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Tests; no reserved address or bit is written by the core model
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(37932));
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1;
        // Window top and data-space offset
        d = $urandom;
        wr(OP_IO_WRITE, 16'h003f, d);
        rd_io(16'h003f, d);
        req(OP_DATA_LOAD_INSTRS, 16'h005f, 3'h0, 8'h00, 1'b0, 1'b0, d, 1'b1);
        d = $urandom;
        wr(OP_DATA_STORE_INSTRS, 16'h0020, d);
        rd_io(16'h0000, d);
        $display("test window and offset done");
        // Every operation just outside its range is refused
        for (int i = 0; i < 8; i++)
            req(r_op[i], r_adr[i], 3'h7, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
        $display("test refusals done");
        // Bit set, clear and skip on the top bit-accessible location
        for (int i = 0; i < 4; i++)
        begin
            d = $urandom;
            b = 3'(i * 2 + 1);
            e = 8'h01 << b;
            wr(OP_IO_WRITE, 16'h001f, d);
            req(OP_IO_BIT_SET_INSTR, 16'h001f, b, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
            rd_io(16'h001f, d | e);
            req(OP_SKIP_IF_IO_BIT_HIGH, 16'h001f, b, 8'h00, 1'b0, 1'b1, 8'h00, 1'b0);
            req(OP_IO_BIT_CLEAR_INSTR, 16'h001f, b, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
            rd_io(16'h001f, d & ~e);
            req(OP_SKIP_IF_IO_BIT_LOW, 16'h001f, b, 8'h00, 1'b0, 1'b1, 8'h00, 1'b0);
            req(OP_SKIP_IF_IO_BIT_HIGH, 16'h001f, b, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        end
        $display("test bit access done");
        // Clearable flags: a written one clears, a bit set clears flags read as one
        wr(OP_IO_WRITE, {8'h00, W1C_REG_IDX}, 8'h0f);
        rd_io({8'h00, W1C_REG_IDX}, 8'h00);
        @(negedge clk_i);
        flag_set_i = 1;
        flag_set_idx_i = W1C_REG_IDX;
        flag_set_bits_i = 8'h0f;
        @(negedge clk_i);
        flag_set_i = 0;
        wr(OP_IO_WRITE, {8'h00, W1C_REG_IDX}, 8'h01);
        rd_io({8'h00, W1C_REG_IDX}, 8'h0e);
        req(OP_IO_BIT_SET_INSTR, {8'h00, W1C_REG_IDX}, 3'h5, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
        rd_io({8'h00, W1C_REG_IDX}, 8'h20);
        $display("test clearable flags done");
        // Extended range: store normally, SRAM in compatibility mode
        d = $urandom;
        e = ~d;
        wr(OP_DATA_STORE_INSTRS, 16'h00ff, d);
        req(OP_DATA_LOAD_INSTRS, 16'h00ff, 3'h0, 8'h00, 1'b0, 1'b0, d, 1'b1);
        wr(OP_DATA_STORE_INSTRS, 16'h0090, e);
        @(negedge clk_i);
        compat_mode_i = 1;
        wr(OP_DATA_STORE_INSTRS, 16'h0090, d);
        req(OP_DATA_LOAD_INSTRS, 16'h0090, 3'h0, 8'h00, 1'b0, 1'b0, d, 1'b1);
        @(negedge clk_i);
        compat_mode_i = 0;
        req(OP_DATA_LOAD_INSTRS, 16'h0090, 3'h0, 8'h00, 1'b0, 1'b0, e, 1'b1);
        repeat (4) @(negedge clk_i);
        check_bit(exp_q.size() == 0, 1'b1, "answers missing");
        $display("test extended range done");
        tally_and_finish();
    end
endmodule : io_space_address_decoder_test
